// >>> ioa_pkg.sv
package ioa_pkg;

  // Bank locations of the I/O settings parameters (byte granular, little endian)
  localparam logic [7:0] LOC_ALT      = 8'h02;
  localparam logic [7:0] LOC_EDGE     = 8'h03;
  localparam logic [7:0] LOC_SLP_MODE = 8'h04;
  localparam logic [7:0] LOC_SLP_DIR  = 8'h05;
  localparam logic [7:0] LOC_SLP_LVL  = 8'h06;
  localparam logic [7:0] LOC_DAC0     = 8'h07;
  localparam logic [7:0] LOC_DAC1     = 8'h09;
  localparam logic [7:0] LOC_SAMPLE   = 8'h0b;
  localparam logic [7:0] LOC_THR      = 8'h0f;
  localparam logic [7:0] LOC_TRIG     = 8'h1b;
  localparam logic [7:0] LOC_RPT      = 8'h1c;
  localparam logic [7:0] LOC_PREDLY   = 8'h20;
  localparam logic [7:0] LOC_MIRROR   = 8'h21;
  localparam logic [7:0] LOC_DACREF   = 8'h22;
  localparam logic [7:0] LOC_ADCREF   = 8'h23;
  localparam logic [7:0] LOC_AVG      = 8'h24;
  localparam logic [7:0] LOC_EXT_ADC  = 8'h25;
  localparam logic [7:0] LOC_EXT_DAC  = 8'h29;
  localparam logic [7:0] LOC_VCC_ADC  = 8'h2d;
  localparam logic [7:0] LOC_VCC_DAC  = 8'h31;
  localparam logic [7:0] LOC_DIFF     = 8'h3d;
  localparam logic [7:0] LOC_DIFF_CAL = 8'h40;
  localparam logic [7:0] LOC_LAST     = 8'h47;
  localparam int         NREG         = 72;

  // Reference selector codes
  localparam logic [1:0] REF_EXT = 2'h0;
  localparam logic [1:0] REF_VCC = 2'h1;
  localparam logic [1:0] REF_OFF = 2'h3;

  // Trigger mask bit positions
  localparam int TRG_ADC0 = 5;
  localparam int TRG_TIMER = 4;

  // Reading ranges
  localparam logic signed [18:0] SE_MIN   = 19'sh00000;
  localparam logic signed [18:0] SE_MAX   = 19'sh007ff;
  localparam logic signed [18:0] DIFF_MIN = -19'sh00800;
  localparam logic signed [18:0] DIFF_MAX = 19'sh007ff;
  localparam logic signed [18:0] DAC_MAX  = 19'sh00fff;

  // Timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int TICK_MS       = 10;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int MS_CYCLES     = CLK_HZ / 1000;
  localparam int SCALE_SHIFT   = 15;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_AVG    = 2'b10,
    ST_FIN    = 2'b11
  } ioa_state_t;

  function automatic logic [7:0] ioa_reset_byte(input int idx);
    case (idx)
      'h03, 'h0b, 'h1b, 'h24:                       return 8'h01 * ((idx == 'h0b) ? 8'h0a : 8'h01);
      'h10, 'h14, 'h18:                             return 8'hf8;
      'h11, 'h15, 'h19:                             return 8'hff;
      'h12, 'h16, 'h1a:                             return 8'h07;
      'h1c:                                         return 8'hb8;
      'h1d:                                         return 8'h0b;
      'h20:                                         return 8'h08;
      'h26, 'h2a, 'h2e, 'h32, 'h36, 'h3a, 'h41, 'h45: return 8'h80;
      default:                                      return 8'h00;
    endcase
  endfunction : ioa_reset_byte

  function automatic logic [7:0] ioa_write_mask(input int idx);
    case (idx)
      'h00, 'h01, 'h02, 'h04, 'h05: return 8'h3f;
      'h08, 'h0a:                   return 8'h0f;
      'h21:                         return 8'h01;
      'h22, 'h23:                   return 8'h03;
      default:                      return 8'hff;
    endcase
  endfunction : ioa_write_mask

endpackage : ioa_pkg

// >>> ioa_core.sv
// How it works
// - Override mask bit selects sleep pin configuration
// - Alternate pin 4 sleeps from level bit 7
// - Sleep direction bit one means output
// - Level bits: pins, transmit, handshake pair
// - Level one drives high or pulls up
// - Transmit bit low idles line low asleep when any pin override or alternate pin 4 is set
// - Startup loads both DAC start values
// - Sample all channels each sample interval
// - Fire below low or above high limit
// - Refire only after returning inside limits
// - One report per crossing with bank
// - Trigger mask bit layout as documented
// - Any enabled source sends one report
// - Base nodes never emit event reports
// - Periodic report every interval, 10 ms counts
// - Wait settle milliseconds after wake before sampling
// - Mirroring copies received pins and ADCs
// - Mirroring blocked in differential mode
// - Two-bit reference codes, three disables converter
// - Reading averages 1 to 255 measurements
// - Scale over 32768 plus offset, per reference
// - Single-ended three readings, differential two signed
`timescale 1ns/1ps
`default_nettype none

module ioa_core
  import ioa_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int MS_CYC   = MS_CYCLES
) (
  input  wire logic        clk,               // 50 MHz clock
  input  wire logic        rst,               // Async reset, active high
  input  wire logic        reg_wr,            // Parameter write strobe
  input  wire logic        reg_rd,            // Parameter read strobe
  input  wire logic [7:0]  reg_addr,          // Parameter location
  input  wire logic [7:0]  reg_wdata,         // Write byte
  output var  logic [7:0]  reg_rdata,         // Read byte, one cycle later
  input  wire logic        node_is_base,      // Node acts as base
  input  wire logic        sleeping,          // Module asleep
  input  wire logic        wake_pulse,        // Wakeup event
  input  wire logic [5:0]  gpio_in,           // Pin levels
  input  wire logic [5:0]  gpio_act_dir,      // Active-mode directions
  input  wire logic [5:0]  gpio_act_out,      // Active-mode levels or pull-ups
  input  wire logic        txd_act,           // Active radio transmit level
  input  wire logic        cts_act_n,         // Active clear-to-send level
  input  wire logic        dcd_act_n,         // Active carrier-detect level
  input  wire logic [11:0] adc_raw0,          // Converter channel 0
  input  wire logic [11:0] adc_raw1,          // Converter channel 1
  input  wire logic [11:0] adc_raw2,          // Converter channel 2
  input  wire logic        rx_report_valid,   // Received report strobe
  input  wire logic [5:0]  rx_gpio,           // Received report pins
  input  wire logic [15:0] rx_adc0,           // Received report ADC0
  input  wire logic [15:0] rx_adc1,           // Received report ADC1
  output var  logic [5:0]  gpio_out,          // Pin output level
  output var  logic [5:0]  gpio_oe,           // Pin output enable
  output var  logic [5:0]  gpio_pullup,       // Pin pull-up enable
  output var  logic        radio_txd,         // Radio serial transmit
  output var  logic        host_cts_n,        // Clear-to-send
  output var  logic        carrier_detect_n,  // Carrier detect
  output var  logic [11:0] dac_zero,          // DAC0 code
  output var  logic [11:0] dac_one,           // DAC1 code
  output var  logic        dac_enable,        // DACs on
  output var  logic        adc_enable,        // ADCs on
  output var  logic        report_valid,      // Event report pulse
  output var  logic [7:0]  report_flags,      // Sources in this report
  output var  logic [15:0] report_adc0,       // Bank ADC0
  output var  logic [15:0] report_adc1,       // Bank ADC1
  output var  logic [15:0] report_adc2,       // Bank ADC2
  output var  logic [5:0]  report_gpio        // Bank pins
);

  typedef struct packed {
    logic [NREG-1:0][7:0] regs;
    logic [7:0]           rdata;
    ioa_state_t           st;
    logic [19:0]          tick_cnt;
    logic [19:0]          ms_cnt;
    logic [31:0]          samp_cnt;
    logic [31:0]          rpt_cnt;
    logic [7:0]           settle_left;
    logic                 settle_pend;
    logic                 per_due;
    logic [2:0][19:0]     acc;
    logic [7:0]           n;
    logic [2:0][15:0]     reading;
    logic [2:0]           outside;
    logic [3:0]           gpio_prev;
    logic [5:0]           gpio_snap;
    logic                 started;
    logic                 mir_valid;
    logic [1:0]           mir_pins;
    logic [5:0]           p_out;
    logic [5:0]           p_oe;
    logic [5:0]           p_pu;
    logic                 txd;
    logic                 cts_n;
    logic                 dcd_n;
    logic [11:0]          dac0;
    logic [11:0]          dac1;
    logic                 dac_en;
    logic                 adc_en;
    logic                 rpt_v;
    logic [7:0]           rpt_flags;
    logic [5:0]           rpt_gpio;
  } ioa_regs_t;

  ioa_regs_t cur;
  ioa_regs_t next_cur;

  function automatic logic signed [18:0] correct(input logic signed [16:0] v,
                                                 input logic [15:0] sc,
                                                 input logic [15:0] off);
    logic signed [33:0] p;
    p = v * $signed({1'b0, sc});
    return 19'(p >>> SCALE_SHIFT) + 19'($signed(off));
  endfunction : correct

  function automatic logic signed [18:0] clamp(input logic signed [18:0] v,
                                               input logic signed [18:0] lo,
                                               input logic signed [18:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  // Field views of the parameter bytes
  logic [5:0]  alt_mask, slp_mask, slp_dir;
  logic [7:0]  slp_lvl, edge_cfg, trig_en, predelay, avg_cnt;
  logic [31:0] samp_ivl, rpt_ivl;
  logic [1:0]  dac_ref, adc_ref;
  logic        mirror_on, diff_mode, sleep_cfg;
  logic [15:0] adc_sc, adc_off, dac_sc, dac_off;

  assign alt_mask  = cur.regs[LOC_ALT][5:0];
  assign edge_cfg  = cur.regs[LOC_EDGE];
  assign slp_mask  = cur.regs[LOC_SLP_MODE][5:0];
  assign slp_dir   = cur.regs[LOC_SLP_DIR][5:0];
  assign slp_lvl   = cur.regs[LOC_SLP_LVL];
  assign samp_ivl  = {cur.regs[LOC_SAMPLE+3], cur.regs[LOC_SAMPLE+2],
                      cur.regs[LOC_SAMPLE+1], cur.regs[LOC_SAMPLE]};
  assign trig_en   = cur.regs[LOC_TRIG];
  assign rpt_ivl   = {cur.regs[LOC_RPT+3], cur.regs[LOC_RPT+2],
                      cur.regs[LOC_RPT+1], cur.regs[LOC_RPT]};
  assign predelay  = cur.regs[LOC_PREDLY];
  assign dac_ref   = cur.regs[LOC_DACREF][1:0];
  assign adc_ref   = cur.regs[LOC_ADCREF][1:0];
  assign avg_cnt   = (cur.regs[LOC_AVG] == 8'h00) ? 8'h01 : cur.regs[LOC_AVG];
  assign diff_mode = cur.regs[LOC_DIFF] == 8'h01;
  assign mirror_on = cur.regs[LOC_MIRROR][0] && !diff_mode;
  assign sleep_cfg = sleeping && (slp_mask != 6'h00 || alt_mask[4]);
  assign adc_sc  = (adc_ref == REF_VCC) ? {cur.regs[LOC_VCC_ADC+1], cur.regs[LOC_VCC_ADC]}
                                        : {cur.regs[LOC_EXT_ADC+1], cur.regs[LOC_EXT_ADC]};
  assign adc_off = (adc_ref == REF_VCC) ? {cur.regs[LOC_VCC_ADC+3], cur.regs[LOC_VCC_ADC+2]}
                                        : {cur.regs[LOC_EXT_ADC+3], cur.regs[LOC_EXT_ADC+2]};
  assign dac_sc  = (dac_ref == REF_VCC) ? {cur.regs[LOC_VCC_DAC+1], cur.regs[LOC_VCC_DAC]}
                                        : {cur.regs[LOC_EXT_DAC+1], cur.regs[LOC_EXT_DAC]};
  assign dac_off = (dac_ref == REF_VCC) ? {cur.regs[LOC_VCC_DAC+3], cur.regs[LOC_VCC_DAC+2]}
                                        : {cur.regs[LOC_EXT_DAC+3], cur.regs[LOC_EXT_DAC+2]};

  // Per-pin sleep and active configuration
  logic [5:0] pin_out, pin_oe, pin_pu;
  for (genvar i = 0; i < 6; i++) begin : g_pin
    logic alt4, ovr, act_lvl;
    assign alt4    = (i == 4) && alt_mask[4];
    assign ovr     = sleeping && slp_mask[i] && !alt4;
    assign act_lvl = (mirror_on && cur.mir_valid && (i == 2 || i == 3)) ?
                     cur.mir_pins[i % 2] : gpio_act_out[i];
    always_comb begin
      if (sleeping && alt4) begin
        pin_oe[i]  = 1'b1;
        pin_out[i] = slp_lvl[7];
        pin_pu[i]  = 1'b0;
      end else if (ovr) begin
        pin_oe[i]  = slp_dir[i];
        pin_out[i] = slp_lvl[i];
        pin_pu[i]  = !slp_dir[i] && slp_lvl[i];
      end else begin
        pin_oe[i]  = gpio_act_dir[i];
        pin_out[i] = act_lvl;
        pin_pu[i]  = !gpio_act_dir[i] && act_lvl;
      end
    end
  end

  // Averages and corrected readings of the finished cycle
  logic [2:0][11:0]        avg;
  logic signed [18:0]      corr [3];
  logic [2:0]              out_now;
  for (genvar c = 0; c < 3; c++) begin : g_chan
    // Wrapped indices keep the unused third channel inside the bank and the average array
    localparam int NXT = (c + 1) % 3;
    localparam int CAL = LOC_DIFF_CAL + 4 * (c % 2);
    logic signed [15:0] lo, hi;
    assign avg[c] = 12'(cur.acc[c] / {12'h000, avg_cnt});
    assign lo = $signed({cur.regs[LOC_THR+4*c+1], cur.regs[LOC_THR+4*c]});
    assign hi = $signed({cur.regs[LOC_THR+4*c+3], cur.regs[LOC_THR+4*c+2]});
    always_comb begin
      if (!diff_mode) begin
        corr[c] = clamp(correct(17'($signed({1'b0, avg[c]})), adc_sc, adc_off),
                        SE_MIN, SE_MAX);
      end else if (c < 2) begin
        corr[c] = clamp(correct(17'($signed({1'b0, avg[NXT]}) - $signed({1'b0, avg[0]})),
                                {cur.regs[CAL+1], cur.regs[CAL]},
                                {cur.regs[CAL+3], cur.regs[CAL+2]}),
                        DIFF_MIN, DIFF_MAX);
      end else begin
        corr[c] = 19'sh00000;
      end
    end
    assign out_now[c] = (corr[c] < 19'(lo)) || (corr[c] > 19'(hi));
  end

  logic [3:0] gpio_edge;
  for (genvar g = 0; g < 4; g++) begin : g_edge
    logic rise, fall;
    assign rise = gpio_in[g] && !cur.gpio_prev[g];
    assign fall = !gpio_in[g] && cur.gpio_prev[g];
    assign gpio_edge[g] = (edge_cfg[2*g+1:2*g] == 2'b00) ? fall :
                          (edge_cfg[2*g+1:2*g] == 2'b10) ? (rise || fall) : rise;
  end

  logic tick, ms_pulse, samp_due, rpt_due;
  logic [7:0] fire;
  logic signed [18:0] dac_a, dac_b;

  assign tick     = cur.tick_cnt == 20'(TICK_CYC - 1);
  assign ms_pulse = cur.ms_cnt == 20'(MS_CYC - 1);
  assign samp_due = tick && (cur.samp_cnt + 32'h1 >= samp_ivl);
  assign rpt_due  = tick && trig_en[TRG_TIMER] && (cur.rpt_cnt + 32'h1 >= rpt_ivl);

  always_comb begin
    next_cur          = cur;
    next_cur.rpt_v    = 1'b0;
    next_cur.tick_cnt = tick ? 20'h00000 : cur.tick_cnt + 20'h1;
    next_cur.ms_cnt   = ms_pulse ? 20'h00000 : cur.ms_cnt + 20'h1;
    next_cur.rdata    = 8'h00;
    fire              = {4'h0, gpio_edge} & trig_en;
    dac_a             = 19'sh00000;
    dac_b             = 19'sh00000;

    if (reg_wr && reg_addr <= LOC_LAST) begin
      next_cur.regs[reg_addr] = reg_wdata & ioa_write_mask(int'(reg_addr));
    end
    if (reg_rd && reg_addr <= LOC_LAST) begin
      next_cur.rdata = cur.regs[reg_addr];
    end

    if (tick) begin
      next_cur.samp_cnt = samp_due ? 32'h0 : cur.samp_cnt + 32'h1;
      next_cur.rpt_cnt  = rpt_due ? 32'h0 : cur.rpt_cnt + 32'h1;
    end
    if (rpt_due) begin
      next_cur.per_due = 1'b1;
    end
    if (wake_pulse) begin
      next_cur.settle_pend = 1'b1;
      next_cur.settle_left = predelay;
    end

    case (cur.st)
      ST_IDLE: begin
        if (samp_due || rpt_due || cur.per_due) begin
          next_cur.n   = 8'h00;
          next_cur.acc = '0;
          if (adc_ref == REF_OFF) begin
            next_cur.st = ST_FIN;
          end else if (cur.settle_pend || wake_pulse) begin
            next_cur.st = ST_SETTLE;
          end else begin
            next_cur.st = ST_AVG;
          end
        end
      end
      ST_SETTLE: begin
        next_cur.settle_pend = wake_pulse;
        if (cur.settle_left == 8'h00) begin
          next_cur.st = ST_AVG;
        end else if (ms_pulse) begin
          next_cur.settle_left = cur.settle_left - 8'h01;
        end
      end
      ST_AVG: begin
        next_cur.acc[0] = cur.acc[0] + {8'h00, adc_raw0};
        next_cur.acc[1] = cur.acc[1] + {8'h00, adc_raw1};
        next_cur.acc[2] = cur.acc[2] + {8'h00, adc_raw2};
        next_cur.n      = cur.n + 8'h01;
        if (cur.n + 8'h01 == avg_cnt) begin
          next_cur.st = ST_FIN;
        end
      end
      ST_FIN: begin
        next_cur.st = ST_IDLE;
        next_cur.gpio_snap = gpio_in;
        next_cur.per_due   = rpt_due;
        if (cur.per_due) begin
          fire[TRG_TIMER] = 1'b1;
        end
        if (adc_ref != REF_OFF) begin
          for (int c = 0; c < 3; c++) begin
            next_cur.reading[c] = corr[c][15:0];
            if (out_now[c] && !cur.outside[c] && trig_en[TRG_ADC0+c]) begin
              fire[TRG_ADC0+c] = 1'b1;
            end
          end
          next_cur.outside = out_now;
        end
      end
      default: next_cur.st = ST_IDLE;
    endcase
    next_cur.gpio_prev = gpio_in[3:0];

    if (fire != 8'h00 && !node_is_base) begin
      next_cur.rpt_v     = 1'b1;
      next_cur.rpt_flags = fire;
      next_cur.rpt_gpio  = {gpio_in[5:4], next_cur.gpio_snap[3:2], gpio_in[1:0]};
    end

    if (!cur.started) begin
      next_cur.started = 1'b1;
      dac_a = correct(17'($signed({5'h00, cur.regs[LOC_DAC0+1][3:0], cur.regs[LOC_DAC0]})),
                      dac_sc, dac_off);
      dac_b = correct(17'($signed({5'h00, cur.regs[LOC_DAC1+1][3:0], cur.regs[LOC_DAC1]})),
                      dac_sc, dac_off);
      next_cur.dac0 = 12'(clamp(dac_a, SE_MIN, DAC_MAX));
      next_cur.dac1 = 12'(clamp(dac_b, SE_MIN, DAC_MAX));
    end else if (rx_report_valid && mirror_on) begin
      next_cur.mir_valid = 1'b1;
      next_cur.mir_pins  = rx_gpio[1:0];
      dac_a = correct(17'($signed({1'b0, rx_adc0})), dac_sc, dac_off);
      dac_b = correct(17'($signed({1'b0, rx_adc1})), dac_sc, dac_off);
      next_cur.dac0 = 12'(clamp(dac_a, SE_MIN, DAC_MAX));
      next_cur.dac1 = 12'(clamp(dac_b, SE_MIN, DAC_MAX));
    end

    next_cur.p_out  = pin_out;
    next_cur.p_oe   = pin_oe;
    next_cur.p_pu   = pin_pu;
    // Low transmit level saves current but the far end sees a break on wake
    next_cur.txd    = sleep_cfg ? slp_lvl[6] : txd_act;
    next_cur.cts_n  = sleep_cfg ? slp_lvl[7] : cts_act_n;
    next_cur.dcd_n  = sleep_cfg ? slp_lvl[7] : dcd_act_n;
    next_cur.dac_en = dac_ref != REF_OFF;
    next_cur.adc_en = adc_ref != REF_OFF;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur <= '0;
      for (int k = 0; k < NREG; k++) begin
        cur.regs[k] <= ioa_reset_byte(k);
      end
      cur.st     <= ST_IDLE;
      cur.txd    <= 1'b1;
      cur.cts_n  <= 1'b1;
      cur.dcd_n  <= 1'b1;
      cur.dac_en <= 1'b1;
      cur.adc_en <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata        = cur.rdata;
  assign gpio_out         = cur.p_out;
  assign gpio_oe          = cur.p_oe;
  assign gpio_pullup      = cur.p_pu;
  assign radio_txd        = cur.txd;
  assign host_cts_n       = cur.cts_n;
  assign carrier_detect_n = cur.dcd_n;
  assign dac_zero         = cur.dac0;
  assign dac_one          = cur.dac1;
  assign dac_enable       = cur.dac_en;
  assign adc_enable       = cur.adc_en;
  assign report_valid     = cur.rpt_v;
  assign report_flags     = cur.rpt_flags;
  assign report_adc0      = cur.reading[0];
  assign report_adc1      = cur.reading[1];
  assign report_adc2      = cur.reading[2];
  assign report_gpio      = cur.rpt_gpio;

endmodule : ioa_core

`default_nettype wire

// >>> ioa_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ioa_checker (
  input wire logic        clk,           // Clock
  input wire logic        rst,           // Reset
  input wire logic        reg_wr,        // Write strobe
  input wire logic        reg_rd,        // Read strobe
  input wire logic [7:0]  reg_addr,      // Location
  input wire logic [7:0]  reg_wdata,     // Write byte
  input wire logic [7:0]  reg_rdata,     // Read byte
  input wire logic        node_is_base,  // Base node
  input wire logic        sleeping,      // Asleep
  input wire logic [5:0]  gpio_act_dir,  // Active directions
  input wire logic        txd_act,       // Active transmit
  input wire logic [5:0]  gpio_oe,       // Pin enables
  input wire logic        radio_txd,     // Transmit line
  input wire logic [11:0] dac_zero,      // DAC0 code
  input wire logic        adc_enable,    // ADCs on
  input wire logic        report_valid,  // Report pulse
  input wire logic [7:0]  report_flags   // Report sources
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read byte not idle");
  property p_lvl_back; reg_wr && reg_addr == 8'h06 ##1 !(reg_wr && reg_addr == 8'h06)
    ##1 reg_rd && reg_addr == 8'h06 |=> reg_rdata == $past(reg_wdata, 3); endproperty
  a_lvl_back: assert property (p_lvl_back) else $error("level mask readback");
  property p_base_quiet; node_is_base && $past(node_is_base) |-> !report_valid; endproperty
  a_base_quiet: assert property (p_base_quiet) else $error("base sent report");
  property p_adc_off; reg_wr && reg_addr == 8'h23 && reg_wdata[1:0] == 2'h3
    |=> ##[0:1] !adc_enable; endproperty
  a_adc_off: assert property (p_adc_off) else $error("adc not disabled");
  property p_act_dir; !sleeping |=> gpio_oe == $past(gpio_act_dir); endproperty
  a_act_dir: assert property (p_act_dir) else $error("awake direction");
  property p_act_txd; !sleeping |=> radio_txd == $past(txd_act); endproperty
  a_act_txd: assert property (p_act_txd) else $error("awake transmit");
  property p_dac_start; $past(rst, 2) && !$past(rst) |-> dac_zero == 12'h000; endproperty
  a_dac_start: assert property (p_dac_start) else $error("dac start value");
  property p_flags; report_valid |-> report_flags != 8'h00; endproperty
  a_flags: assert property (p_flags) else $error("report without source");
endmodule : ioa_checker
bind ioa_core ioa_checker chk_i (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .node_is_base, .sleeping, .gpio_act_dir, .txd_act, .gpio_oe, .radio_txd,
  .dac_zero, .adc_enable, .report_valid, .report_flags);
`default_nettype wire

// >>> ioa_base_model.sv
`timescale 1ns/1ps
`default_nettype none
module ioa_base_model (
  input  wire logic        clk,           // Clock
  input  wire logic        rst,           // Reset
  input  wire logic        report_valid,  // Report pulse
  input  wire logic [7:0]  report_flags,  // Sources
  input  wire logic [15:0] report_adc0,   // ADC0 reading
  output var  logic [31:0] n_rpt,         // Reports taken
  output var  logic [7:0]  last_flags,    // Last sources
  output var  logic [15:0] last_adc0      // Last ADC0
);
  // Takes every pulse; the base never drops a report, so counts are exact
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      n_rpt <= 32'h0;
      last_flags <= 8'h00;
      last_adc0 <= 16'h0000;
    end else if (report_valid) begin
      n_rpt <= n_rpt + 32'h1;
      last_flags <= report_flags;
      last_adc0 <= report_adc0;
    end
  end
endmodule : ioa_base_model
`default_nettype wire

// >>> io_sleep_adc_event_reporting_tb.sv
`timescale 1ns/1ps
`default_nettype none
module io_sleep_adc_event_reporting_tb;
  logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, node_is_base = 0, sleeping = 0;
  logic wake_pulse = 0, txd_act = 1, cts_act_n = 0, dcd_act_n = 0, rx_report_valid = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, report_flags, last_flags;
  logic [5:0] gpio_in = 6'h28, gpio_act_dir = 6'h0c, gpio_act_out = 6'h00, rx_gpio = 6'h03;
  logic [5:0] gpio_out, gpio_oe, gpio_pullup, report_gpio;
  logic [11:0] adc_raw0 = 12'h400, adc_raw1 = 12'h234, adc_raw2 = 12'h7ff, dac_zero, dac_one;
  logic [15:0] rx_adc0 = 16'h0123, rx_adc1 = 16'h0456, report_adc0, report_adc1;
  logic [15:0] report_adc2, last_adc0;
  logic radio_txd, host_cts_n, carrier_detect_n, dac_enable, adc_enable, report_valid;
  logic [31:0] n_rpt;
  logic [7:0] ra [8] = '{8'h1b, 8'h0b, 8'h1c, 8'h1d, 8'h24, 8'h06, 8'h22, 8'h23};
  logic [7:0] rv [8] = '{8'h01, 8'h0a, 8'hb8, 8'h0b, 8'h01, 8'h00, 8'h00, 8'h00};
  int n_fail = 0, checked = 0, cyc = 0;
  always #10 clk = ~clk;
  // Short tick and millisecond counts keep each sample interval at 200 clocks
  ioa_core #(.TICK_CYC(20), .MS_CYC(5)) dut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .node_is_base, .sleeping, .wake_pulse, .gpio_in, .gpio_act_dir,
    .gpio_act_out, .txd_act, .cts_act_n, .dcd_act_n, .adc_raw0, .adc_raw1, .adc_raw2,
    .rx_report_valid, .rx_gpio, .rx_adc0, .rx_adc1, .gpio_out, .gpio_oe, .gpio_pullup,
    .radio_txd, .host_cts_n, .carrier_detect_n, .dac_zero, .dac_one, .dac_enable,
    .adc_enable, .report_valid, .report_flags, .report_adc0, .report_adc1, .report_adc2,
    .report_gpio);
  ioa_base_model base (.clk, .rst, .report_valid, .report_flags, .report_adc0, .n_rpt,
    .last_flags, .last_adc0);
  task automatic results();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1 reg_wr = 0;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd = 1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 0;
    chk(reg_rdata, exp);
    @(posedge clk);
    #1;
  endtask : rd
  // Counts base-side reports over a window of n clocks
  task automatic span(input int n, input logic [31:0] exp);
    logic [31:0] c0;
    c0 = n_rpt;
    repeat (n) @(posedge clk);
    #1 chk(n_rpt - c0, exp);
  endtask : span
  task automatic rx_pulse();
    rx_report_valid = 1;
    @(posedge clk);
    #1 rx_report_valid = 0;
    repeat (2) @(posedge clk);
    #1;
  endtask : rx_pulse
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    chk({dac_enable, adc_enable}, 2'b11);
    wr(8'h04, 8'hff);
    rd(8'h04, 8'h3f);
    wr(8'h50, 8'h55);
    rd(8'h50, 8'h00);
    wr(8'h05, 8'h0f);
    wr(8'h06, 8'h95);
    rd(8'h06, 8'h95);
    sleeping = 1;
    repeat (2) @(posedge clk);
    #1 chk(gpio_oe, 6'h0f);
    chk(gpio_out & gpio_oe, 6'h05);
    chk(gpio_pullup & ~gpio_oe, 6'h10);
    chk({radio_txd, host_cts_n, carrier_detect_n}, 3'b011);
    wr(8'h04, 8'h00);
    wr(8'h02, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk({gpio_oe, gpio_out[4]}, 7'h39);
    wr(8'h02, 8'h00);
    sleeping = 0;
    wr(8'h1b, 8'h20);
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h04);
    wr(8'h0f, 8'h80);
    wr(8'h10, 8'h01);
    span(450, 0);
    adc_raw0 = 12'h500;
    span(450, 1);
    chk({last_flags, last_adc0}, 24'h200500);
    chk({report_adc1, 10'h000, report_gpio}, 32'h02340028);
    chk(report_adc2, 32'h000007ff);
    adc_raw0 = 12'h400;
    span(450, 0);
    adc_raw0 = 12'h100;
    span(450, 1);
    node_is_base = 1;
    adc_raw0 = 12'h400;
    span(250, 0);
    adc_raw0 = 12'h500;
    span(450, 0);
    node_is_base = 0;
    wr(8'h1b, 8'h10);
    wr(8'h1c, 8'h05);
    wr(8'h1d, 8'h00);
    repeat (120) @(posedge clk);
    #1 span(200, 2);
    chk(last_flags, 8'h10);
    wr(8'h21, 8'h01);
    rx_pulse();
    chk({dac_zero, dac_one}, 24'h123456);
    chk(gpio_out[3:2], 2'b11);
    wr(8'h3d, 8'h01);
    rx_adc0 = 16'h0777;
    rx_pulse();
    chk({dac_zero, dac_one}, 24'h123456);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h03);
    wr(8'h23, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk({dac_enable, adc_enable}, 2'b00);
    results();
  end
endmodule : io_sleep_adc_event_reporting_tb
`default_nettype wire
